/* File: design/oats_pkg.sv */
// package: constants and types of the oversampled acquisition sequencer
package oats_pkg;

  // =====================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 50; // 20 MHz clock
  localparam logic [31:0] TIME_STEP = 32'(CLK_PERIOD_NS); // ns added per clock
  localparam logic [31:0] SAMPLE_MIN_NS = 32'h0000_2710; // 10000 ns least sample period
  localparam int unsigned LED_MS = 1; // lamp time base in ms
  localparam int unsigned LED_MS_CYC = LED_MS * 1_000_000 / CLK_PERIOD_NS; // 20000 cycles
  localparam int unsigned LED_FRAME_MS = 1200; // lamp pattern frame
  localparam int unsigned LED_UNI_MS = 200; // even flash half period
  localparam int unsigned LED_SLOW_ON_MS = 200; // slow flash on time per frame
  localparam int unsigned LED_FAST_MS = 50; // rapid flash half period

  // =====================================================
  // buffer geometry
  localparam int unsigned MAX_OVERSAMPLE = 100; // factor limit
  localparam logic [6:0] MAX_N = 7'h64; // same limit at index width
  localparam int unsigned SAMPLE_W = 16; // bits per channel sample
  localparam int unsigned WORD_W = 2 * SAMPLE_W; // one word carries both channels
  localparam logic [5:0] DIV_STEPS = 6'h20; // serial divider steps

  // =====================================================
  // bus state machine codes
  typedef enum logic [3:0] {
    OATS_ESM_INIT = 4'h1,
    OATS_ESM_PREOP = 4'h2,
    OATS_ESM_BOOT = 4'h3,
    OATS_ESM_SAFEOP = 4'h4,
    OATS_ESM_OP = 4'h8
  } oats_esm_t;

  // publish sequence, gray along idle -> data -> stamp
  typedef enum logic [1:0] {
    OATS_PUB_IDLE = 2'b00,
    OATS_PUB_DATA = 2'b01,
    OATS_PUB_STAMP = 2'b11
  } oats_pub_t;

endpackage // oats_pkg

/* File: design/oats_stream_if.sv */
// interface: word stream with valid and ready between sequencer parts
`timescale 1ns/10ps
interface oats_stream_if;
  logic valid; // word offered
  logic ready; // word accepted
  logic [31:0] data; // word
  logic last; // final word of a block
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface // oats_stream_if

/* File: design/oats_skid_buf.sv */
// module: two-entry buffer between publish logic and process image
`timescale 1ns/10ps
module oats_skid_buf
  import oats_pkg::*;
(
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  oats_stream_if.snk in_s, // filling side
  output logic out_valid, // word available
  input wire logic out_ready, // receiver takes word
  output logic [31:0] out_data, // word, from flops
  output logic out_last // final word flag, from flops
);

  // =====================================================
  // state
  typedef struct packed {
    logic [1:0][32:0] mem; // {last, data} per entry
    logic wp; // write slot
    logic rp; // read slot
    logic [1:0] cnt; // entries held
  } oats_buf_t;

  oats_buf_t s_q;
  oats_buf_t s_d;
  logic push;
  logic pop;

  // honest full and empty drive both handshakes
  assign in_s.ready = (s_q.cnt != 2'd2);
  assign out_valid = (s_q.cnt != 2'd0);
  assign out_data = s_q.mem[s_q.rp][31:0];
  assign out_last = s_q.mem[s_q.rp][32];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_valid && out_ready;

  // next state
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = {in_s.last, in_s.data};
      s_d.wp = ~s_q.wp;
    end
    if (pop) begin
      s_d.rp = ~s_q.rp;
    end
    s_d.cnt = s_q.cnt + 2'(push) - 2'(pop);
  end

  // register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // oats_skid_buf

/* File: design/oats_run_led.sv */
// module: run lamp pattern generator from bus state
`timescale 1ns/10ps
module oats_run_led
  import oats_pkg::*;
#(
  parameter int unsigned MS_CYC = LED_MS_CYC // clocks per millisecond
) (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic [3:0] esm_state, // bus state code
  output logic run_led // lamp drive, high is lit
);

  // =====================================================
  // state
  typedef struct packed {
    logic [14:0] pre; // clocks within one ms
    logic [10:0] ms; // ms within pattern frame
    logic led; // lamp register
  } oats_led_t;

  oats_led_t s_q;
  oats_led_t s_d;
  logic ms_en;

  assign ms_en = (s_q.pre == 15'(MS_CYC - 1)); // one-cycle ms enable
  assign run_led = s_q.led;

  // counters and pattern select
  always_comb begin
    s_d = s_q;
    s_d.pre = ms_en ? 15'd0 : s_q.pre + 15'd1;
    if (ms_en) begin
      s_d.ms = (s_q.ms == 11'(LED_FRAME_MS - 1)) ? 11'd0 : s_q.ms + 11'd1;
    end
    case (esm_state)
      OATS_ESM_PREOP: s_d.led = ((s_q.ms / 11'(LED_UNI_MS)) % 11'd2) == 11'd0;
      OATS_ESM_SAFEOP: s_d.led = s_q.ms < 11'(LED_SLOW_ON_MS);
      OATS_ESM_OP: s_d.led = 1'b1;
      OATS_ESM_BOOT: s_d.led = ((s_q.ms / 11'(LED_FAST_MS)) % 11'd2) == 11'd0;
      default: s_d.led = 1'b0; // init and unknown codes stay dark
    endcase
  end

  // register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // oats_run_led

/* File: design/oats_top.sv */
// module: oversampling trigger sequencer, top level
`timescale 1ns/10ps
module oats_top
  import oats_pkg::*;
#(
  parameter int unsigned LED_MS_CYCLES = LED_MS_CYC // shorten for simulation
) (
  input wire logic clk, // 20 MHz clock
  input wire logic srst, // sync reset, high
  input wire logic time_set, // master loads local time
  input wire logic [31:0] time_set_ns, // value to load
  input wire logic cfg_load, // apply configuration
  input wire logic [31:0] cfg_cycle_ns, // bus cycle time
  input wire logic [6:0] cfg_oversample, // factor n
  input wire logic [31:0] cfg_shift_ns, // signed sample shift
  input wire logic [31:0] cfg_start_ns, // time of first cycle tick
  input wire logic [3:0] esm_state, // bus state code
  input wire logic adc_done, // conversion result valid
  input wire logic [15:0] adc_ch0, // channel 0 result
  input wire logic [15:0] adc_ch1, // channel 1 result
  input wire logic pd_ready, // process image takes word
  output logic pd_valid, // process word offered
  output logic [31:0] pd_data, // process word
  output logic pd_last, // final word of block
  output logic adc_start, // conversion start pulse
  output logic cycle_tick, // once per bus cycle
  output logic sample_tick, // n per bus cycle
  output logic [31:0] local_time, // local time in ns
  output logic cfg_ok, // configuration plausible
  output logic cfg_busy, // period being computed
  output logic run_led // run lamp
);

  // =====================================================
  // state
  typedef struct packed {
    logic [31:0] ltime; // local time
    logic [31:0] next_cyc; // time of next cycle tick
    logic [31:0] next_smp; // time of next sample tick
    logic [31:0] cyc_ns; // cycle time in use
    logic [31:0] shift; // shift in use
    logic [6:0] n; // factor in use
    logic [31:0] quo; // divider quotient, then sample period
    logic [32:0] rem; // divider remainder
    logic [5:0] dcnt; // divider steps left
    logic busy; // divider running
    logic ok; // plausible and running
    logic cyc_t; // cycle tick register
    logic smp_t; // sample tick register
    logic adc_go; // conversion start register
    logic adc_bsy; // conversion pending
    logic cbank; // bank of pending conversion
    logic [6:0] cidx; // index of pending conversion
    logic wbank; // bank being filled
    logic [6:0] widx; // next fill index
    logic [1:0][99:0][31:0] mem; // sample storage, two banks
    logic [31:0] stamp; // next latch timestamp
    oats_pub_t pub; // publish phase
    logic [6:0] ridx; // publish read index
    logic [6:0] pn; // words to publish
  } oats_top_t;

  oats_top_t s_q;
  oats_top_t s_d;
  oats_stream_if pub_s ();

  logic cyc_hit;
  logic smp_hit;
  logic [31:0] cyc_diff;
  logic [31:0] smp_diff;
  logic acq_on;
  logic [32:0] rem_sh;

  // =====================================================
  // tick compare on wrapping time
  assign cyc_diff = s_q.ltime - s_q.next_cyc;
  assign smp_diff = s_q.ltime - s_q.next_smp;
  assign cyc_hit = s_q.ok && !cyc_diff[31];
  assign smp_hit = s_q.ok && !smp_diff[31];
  assign acq_on = (esm_state == OATS_ESM_SAFEOP) || (esm_state == OATS_ESM_OP);
  assign rem_sh = {s_q.rem[31:0], s_q.quo[31]};

  // =====================================================
  // publish stream offer
  assign pub_s.valid = (s_q.pub != OATS_PUB_IDLE);
  assign pub_s.last = (s_q.pub == OATS_PUB_STAMP);
  assign pub_s.data = (s_q.pub == OATS_PUB_STAMP) ? s_q.stamp :
                      s_q.mem[~s_q.wbank][s_q.ridx];

  // =====================================================
  // outputs
  assign local_time = s_q.ltime;
  assign cycle_tick = s_q.cyc_t;
  assign sample_tick = s_q.smp_t;
  assign adc_start = s_q.adc_go;
  assign cfg_ok = s_q.ok;
  assign cfg_busy = s_q.busy;

  // =====================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.cyc_t = 1'b0;
    s_d.smp_t = 1'b0;
    s_d.adc_go = 1'b0;

    // local time, loaded by the master or stepped per clock
    if (time_set) begin
      s_d.ltime = time_set_ns;
    end else begin
      s_d.ltime = s_q.ltime + TIME_STEP;
    end

    // configuration: capture and start period division
    if (cfg_load) begin
      s_d.cyc_ns = cfg_cycle_ns;
      s_d.n = cfg_oversample;
      s_d.shift = cfg_shift_ns;
      s_d.next_cyc = cfg_start_ns;
      s_d.next_smp = cfg_start_ns + cfg_shift_ns;
      s_d.quo = cfg_cycle_ns;
      s_d.rem = '0;
      s_d.dcnt = DIV_STEPS;
      s_d.busy = 1'b1;
      s_d.ok = 1'b0;
      s_d.pub = OATS_PUB_IDLE;
    end else if (s_q.busy) begin
      // restoring divide, one quotient bit per clock
      if (s_q.n == 7'd0) begin
        s_d.busy = 1'b0; // zero factor never becomes plausible
      end else begin
        if (rem_sh >= 33'(s_q.n)) begin
          s_d.rem = rem_sh - 33'(s_q.n);
          s_d.quo = {s_q.quo[30:0], 1'b1};
        end else begin
          s_d.rem = rem_sh;
          s_d.quo = {s_q.quo[30:0], 1'b0};
        end
        s_d.dcnt = s_q.dcnt - 6'd1;
        if (s_q.dcnt == 6'd1) begin
          s_d.busy = 1'b0;
          // plausibility; failure keeps ticks and data off
          s_d.ok = (s_q.n <= MAX_N)
                   && (s_d.rem == 33'd0)
                   && (s_d.quo >= SAMPLE_MIN_NS);
        end
      end
    end else begin
      // cycle tick: swap banks, take stamp, start publish in OP only
      if (cyc_hit) begin
        s_d.cyc_t = 1'b1;
        s_d.next_cyc = s_q.next_cyc + s_q.cyc_ns;
        s_d.wbank = ~s_q.wbank;
        s_d.widx = 7'd0;
        s_d.stamp = s_q.ltime;
        s_d.ridx = 7'd0;
        s_d.pn = s_q.n;
        // a block still being sent is abandoned for the fresh one
        s_d.pub = (esm_state == OATS_ESM_OP) ? OATS_PUB_DATA : OATS_PUB_IDLE;
      end

      // sample tick: equidistant, locked to the cycle schedule
      if (smp_hit) begin
        s_d.smp_t = 1'b1;
        s_d.next_smp = s_q.next_smp + s_q.quo;
        if (acq_on && !s_q.adc_bsy && (s_d.widx < s_q.n)) begin
          s_d.adc_go = 1'b1;
          s_d.adc_bsy = 1'b1;
          s_d.cbank = s_d.wbank;
          s_d.cidx = s_d.widx;
          s_d.widx = s_d.widx + 7'd1;
        end
      end

      // publish sequence toward the buffer
      unique case (s_q.pub)
        OATS_PUB_IDLE: begin
          s_d.pub = s_d.pub; // waits for a cycle tick
        end
        OATS_PUB_DATA: begin
          if (pub_s.ready && !cyc_hit) begin
            s_d.ridx = s_q.ridx + 7'd1;
            if (s_q.ridx == s_q.pn - 7'd1) begin
              s_d.pub = OATS_PUB_STAMP;
            end
          end
        end
        OATS_PUB_STAMP: begin
          if (pub_s.ready && !cyc_hit) begin
            s_d.pub = OATS_PUB_IDLE;
          end
        end
      endcase
    end

    // conversion result into the slot chosen at start
    if (adc_done && s_q.adc_bsy) begin
      s_d.mem[s_q.cbank][s_q.cidx] = {adc_ch1, adc_ch0};
      s_d.adc_bsy = 1'b0;
    end
  end

  // register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================
  // two-entry buffer absorbs receiver stalls
  oats_skid_buf u_buf (
    .clk(clk),
    .srst(srst),
    .in_s(pub_s.snk),
    .out_valid(pd_valid),
    .out_ready(pd_ready),
    .out_data(pd_data),
    .out_last(pd_last)
  );

  // =====================================================
  // run lamp
  oats_run_led #(
    .MS_CYC(LED_MS_CYCLES)
  ) u_led (
    .clk(clk),
    .srst(srst),
    .esm_state(esm_state),
    .run_led(run_led)
  );

endmodule // oats_top

/* File: tb/oats_sva.sv */
// checker: timing relations at the sequencer's ports
`timescale 1ns/10ps
module oats_sva (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic time_set, // time load
  input wire logic cfg_load, // config apply
  input wire logic [6:0] cfg_oversample, // factor n
  input wire logic [3:0] esm_state, // bus state
  input wire logic pd_ready, // word taken
  input wire logic pd_valid, // word offered
  input wire logic [31:0] pd_data, // word
  input wire logic pd_last, // block end
  input wire logic adc_start, // start pulse
  input wire logic cycle_tick, // cycle pulse
  input wire logic sample_tick, // sample pulse
  input wire logic [31:0] local_time, // time in ns
  input wire logic cfg_ok, // config plausible
  input wire logic cfg_busy // division running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [7:0] cnt_q; // sample ticks since last cycle tick
  logic seen_q; // a cycle tick has opened the count
  // =====================================================
  // helper: count sample ticks between cycle ticks
  always_ff @(posedge clk) begin
    if (srst || cfg_load) begin
      cnt_q <= 8'h00;
      seen_q <= 1'b0;
    end else if (cycle_tick) begin
      cnt_q <= {7'h00, sample_tick};
      seen_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {7'h00, sample_tick};
    end
  end
  // division: busy for the full 32 steps then drops
  sequence busy_run_s;
    cfg_busy ##32 !cfg_busy;
  endsequence
  // =====================================================
  // assertions
  time_step_a: assert property (!time_set |=> local_time == $past(local_time) + 32'h0000_0032)
    else $error("local time did not advance one clock step");
  cycle_pulse_a: assert property (cycle_tick |=> !cycle_tick)
    else $error("cycle tick longer than one clock");
  start_tied_a: assert property (adc_start |-> sample_tick)
    else $error("conversion start without sample tick");
  sample_count_a: assert property (seen_q && cycle_tick |-> cnt_q == {1'b0, cfg_oversample})
    else $error("sample ticks per cycle differ from factor");
  quiet_bad_a: assert property (!cfg_ok && !$past(cfg_ok) |-> !cycle_tick && !sample_tick)
    else $error("tick while configuration not plausible");
  cfg_timing_a: assert property (cfg_load && cfg_oversample != 7'h00 |=> busy_run_s)
    else $error("configuration check time wrong");
  zero_factor_a: assert property (cfg_load && cfg_oversample == 7'h00 |=> cfg_busy ##1 !cfg_busy && !cfg_ok)
    else $error("zero factor not refused at once");
  pd_hold_a: assert property (pd_valid && !pd_ready |=> pd_valid && $stable(pd_data) && $stable(pd_last))
    else $error("process word changed while stalled");
  pub_after_a: assert property (cycle_tick && esm_state == 4'h8 && !pd_valid |-> ##2 pd_valid)
    else $error("block not offered after cycle tick");
endmodule // oats_sva
bind oats_top oats_sva u_sva (.clk(clk), .srst(srst), .time_set(time_set), .cfg_load(cfg_load),
  .cfg_oversample(cfg_oversample), .esm_state(esm_state), .pd_ready(pd_ready),
  .pd_valid(pd_valid), .pd_data(pd_data), .pd_last(pd_last), .adc_start(adc_start),
  .cycle_tick(cycle_tick), .sample_tick(sample_tick), .local_time(local_time),
  .cfg_ok(cfg_ok), .cfg_busy(cfg_busy));

/* File: tb/oats_far_end.sv */
// far-end model: converter answering starts, process image taking words
`timescale 1ns/10ps
module oats_far_end (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic adc_start, // conversion request
  output logic adc_done, // result strobe
  output logic [15:0] adc_ch0, // channel 0 result
  output logic [15:0] adc_ch1, // channel 1 result
  output logic pd_ready // word taken
);
  logic busy_q; // conversion running
  logic [1:0] wait_q; // cycles left
  logic [15:0] seq_q; // result source
  logic [1:0] ph_q; // stall phase
  // =====================================================
  // converter answers four clocks after the start pulse; results toggle between answers
  always_ff @(posedge clk) begin
    adc_done <= 1'b0;
    adc_ch0 <= ~adc_ch0;
    adc_ch1 <= ~adc_ch1;
    ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    pd_ready <= (ph_q != 2'h0); // stall one clock in three
    if (srst) begin
      busy_q <= 1'b0;
      seq_q <= 16'h1234;
      ph_q <= 2'h0;
      adc_ch0 <= 16'h0000;
      adc_ch1 <= 16'hFFFF;
    end else if (adc_start) begin
      busy_q <= 1'b1;
      wait_q <= 2'h2;
    end else if (busy_q && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      adc_done <= 1'b1;
      adc_ch0 <= seq_q;
      adc_ch1 <= seq_q ^ 16'hA5A5;
      seq_q <= seq_q + 16'h0001;
    end
  end
endmodule // oats_far_end

/* File: tb/oats_top_tb.sv */
// testbench: self-checking run of the oversampling sequencer
`timescale 1ns/10ps
module oats_top_tb
  import oats_pkg::*;
;
  typedef struct {logic [31:0] cyc; logic [6:0] n; logic ok;} oats_row_t;
  logic clk, srst, time_set, cfg_load, adc_done, pd_ready, acq;
  logic [31:0] time_set_ns, cfg_cycle_ns, cfg_shift_ns, cfg_start_ns, pd_data, local_time;
  logic [31:0] prev_lt;
  logic [6:0] cfg_oversample;
  logic [3:0] esm_state;
  logic [15:0] adc_ch0, adc_ch1;
  logic pd_valid, pd_last, adc_start, cycle_tick, sample_tick, cfg_ok, cfg_busy, run_led;
  logic [31:0] stamps[$], samples[$];
  int miscompares, checks, gap, blk, nwords, words, w0, k;
  // configuration cases and whether each is plausible
  // the last row is the zero factor, which the divider refuses at once
  oats_row_t rows[7] = '{'{32'h0000_4E20, 7'h02, 1'b1}, '{32'h0000_4E20, 7'h03, 1'b0},
    '{32'h0000_4E20, 7'h04, 1'b0}, '{32'h000F_4240, 7'h64, 1'b1},
    '{32'h000F_6950, 7'h65, 1'b0}, '{32'h0000_4E20, 7'h01, 1'b1},
    '{32'h0000_4E20, 7'h00, 1'b0}};
  oats_top #(.LED_MS_CYCLES(20)) dut (.clk(clk), .srst(srst), .time_set(time_set),
    .time_set_ns(time_set_ns), .cfg_load(cfg_load), .cfg_cycle_ns(cfg_cycle_ns),
    .cfg_oversample(cfg_oversample), .cfg_shift_ns(cfg_shift_ns), .cfg_start_ns(cfg_start_ns),
    .esm_state(esm_state), .adc_done(adc_done), .adc_ch0(adc_ch0), .adc_ch1(adc_ch1),
    .pd_ready(pd_ready), .pd_valid(pd_valid), .pd_data(pd_data), .pd_last(pd_last),
    .adc_start(adc_start), .cycle_tick(cycle_tick), .sample_tick(sample_tick),
    .local_time(local_time), .cfg_ok(cfg_ok), .cfg_busy(cfg_busy), .run_led(run_led));
  oats_far_end far (.clk(clk), .srst(srst), .adc_start(adc_start), .adc_done(adc_done),
    .adc_ch0(adc_ch0), .adc_ch1(adc_ch1), .pd_ready(pd_ready));
  // =====================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #3_000_000;
    miscompares++;
    report_and_stop();
  end
  // =====================================================
  // helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cfg(input logic [31:0] c, input logic [6:0] n, input logic [31:0] sh);
    cfg_cycle_ns = c;
    cfg_oversample = n;
    cfg_shift_ns = sh;
    cfg_start_ns = local_time + 32'h0000_0FA0; // first cycle tick 80 clocks ahead
    cfg_load = 1'b1;
    cyc(1);
    cfg_load = 1'b0;
    cyc(33);
  endtask
  task automatic lamp(input logic [3:0] st, input int win, input int on);
    int cnt;
    cnt = 0;
    esm_state = st;
    cyc(10);
    repeat (win) begin
      cyc(1);
      cnt += (run_led === 1'b1);
    end
    chk("lamp on clocks", 32'(on), 32'(cnt));
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // =====================================================
  // monitor: tick spacing, stamps, samples and block contents
  always @(posedge clk) begin
    if (srst || cfg_load) begin
      gap = -1;
      blk = 0;
      nwords = 0;
      stamps.delete();
      samples.delete();
    end
    if (gap >= 0) gap++;
    if (cycle_tick) begin
      if (gap > 0) chk("tick spacing", cfg_cycle_ns / 50, 32'(gap));
      gap = 0;
      stamps.push_back(prev_lt);
      if (esm_state == 4'h8) chk("sample at cycle", {31'h0, cfg_shift_ns == 0}, {31'h0, sample_tick});
    end
    if (adc_done) samples.push_back({adc_ch1, adc_ch0});
    if (pd_valid && pd_ready) words++;
    if (pd_valid && pd_ready && acq) begin
      if (pd_last) begin
        if (blk > 0) chk("words per block", {25'h0, cfg_oversample}, 32'(nwords));
        if (blk > 0) chk("block stamp", stamps[0], pd_data);
        void'(stamps.pop_front());
        blk++;
        nwords = 0;
      end else begin
        if (blk > 0) chk("sample word", samples.pop_front(), pd_data);
        nwords++;
      end
    end
    prev_lt = local_time;
  end
  // =====================================================
  // main sequence
  initial begin
    srst = 1'b1;
    {time_set, cfg_load, acq} = 3'b000;
    {time_set_ns, cfg_cycle_ns, cfg_shift_ns, cfg_start_ns} = '0;
    cfg_oversample = 7'h00;
    esm_state = 4'h1;
    cyc(16);
    chk("reset outputs", 32'h0, local_time | {28'h0, pd_valid, cfg_ok, cycle_tick, adc_start});
    srst = 1'b0;
    lamp(4'h8, 100, 100);
    lamp(4'h2, 8000, 4000);
    lamp(4'h3, 2000, 1000);
    lamp(4'h4, 24000, 4000);
    lamp(4'h1, 100, 0);
    foreach (rows[i]) begin
      cfg(rows[i].cyc, rows[i].n, 32'h0);
      chk("cfg_ok", {31'h0, rows[i].ok}, {31'h0, cfg_ok});
    end
    // load a time just short of the wrap
    time_set_ns = 32'hFFFF_FFF0;
    time_set = 1'b1;
    cyc(1);
    time_set = 1'b0;
    chk("time load", 32'hFFFF_FFF0, local_time);
    cyc(1);
    chk("time wrap", 32'h0000_0022, local_time);
    // restart close to the wrap so that ticks below straddle it
    time_set_ns = 32'hFFFF_C000;
    time_set = 1'b1;
    cyc(1);
    time_set = 1'b0;
    // acquisition across the wrap, receiver stalling
    esm_state = 4'h8;
    acq = 1'b1;
    cfg(32'h0000_4E20, 7'h02, 32'h0);
    cyc(2000);
    acq = 1'b0;
    chk("blocks seen", 32'h1, {31'h0, blk >= 3});
    // shifted sample ticks lag the cycle tick by 20 clocks
    cfg(32'h0000_4E20, 7'h02, 32'h0000_03E8);
    for (k = 0; k < 1000 && cycle_tick !== 1'b1; k++) cyc(1);
    cyc(20);
    chk("shifted sample", 32'h1, {31'h0, sample_tick});
    cfg(32'h0000_4E20, 7'h01, 32'h0);
    cyc(1000);
    // implausible factor: no process words at all
    cfg(32'h0000_4E20, 7'h03, 32'h0);
    w0 = words;
    cyc(1000);
    chk("words when implausible", 32'(w0), 32'(words));
    // reset in mid-run
    srst = 1'b1;
    cyc(2);
    chk("reset outputs", 32'h0, local_time | {28'h0, pd_valid, cfg_ok, cycle_tick, adc_start});
    srst = 1'b0;
    cyc(5);
    report_and_stop();
  end
endmodule // oats_top_tb
